// ### dph_pkg.sv
// shared constants, register layout and pin carriers for the data port dma handshake
// assumes a single 250 MHz clock and an axi4-lite master on the register side
package dph_pkg;
  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned BUS_W = 16;
  localparam int unsigned PAR_W = 2;
  localparam int unsigned HOST_W = 8;
  localparam int unsigned WORD_W = BUS_W + PAR_W;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned AXI_BYTES = 4;
  localparam int unsigned SYNC_STAGES = 2;

  // address layout: bit PORT_BIT picks the port, bits IDX_HI:IDX_LO pick the word
  localparam int unsigned PORT_BIT = 4;
  localparam int unsigned IDX_HI = 3;
  localparam int unsigned IDX_LO = 2;
  localparam logic [1:0] IDX_CTRL = 2'h0;
  localparam logic [1:0] IDX_STAT = 2'h1;
  localparam logic [1:0] IDX_TXD = 2'h2;

  // control word fields
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned CTRL_MODE_LO = 0;
  localparam int unsigned CTRL_MODE_HI = 1;
  localparam int unsigned CTRL_STB_EN = 2;
  localparam int unsigned CTRL_OE_EN = 3;
  localparam int unsigned CTRL_PAR_EN = 4;
  localparam int unsigned CTRL_REQ_INV = 5;
  localparam int unsigned CTRL_ACK_INV = 6;
  localparam int unsigned CTRL_STB_INV = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h0C;

  // status word fields (data in the low WORD_W bits)
  localparam int unsigned STAT_RX_VALID = 18;
  localparam int unsigned STAT_TX_FULL = 19;
  localparam int unsigned STAT_BUSY = 20;

  // synchroniser lanes of each port
  localparam int unsigned SY_REQ = 0;
  localparam int unsigned SY_ACK = 1;
  localparam int unsigned SY_STB = 2;
  localparam int unsigned SY_N = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SLV_IN = 2'b01,
    MODE_SLV_OUT = 2'b10,
    MODE_MST_IN = 2'b11
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_XIN = 3'b001,
    ST_EIN = 3'b010,
    ST_XOUT = 3'b011,
    ST_EOUT = 3'b100,
    ST_REQ = 3'b101,
    ST_ACK = 3'b110
  } xfer_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LOW = 2'b01,
    HS_WAIT = 2'b10
  } host_e;

  typedef struct packed {
    logic dma_request;
    logic dma_acknowledge;
    logic port_write_strobe;
    logic [BUS_W-1:0] xfer_bus;
    logic [PAR_W-1:0] xfer_parity;
  } port_in_s;

  typedef struct packed {
    logic dma_request;
    logic dma_request_oe;
    logic dma_acknowledge;
    logic dma_acknowledge_oe;
    logic port_write_strobe;
    logic port_write_strobe_oe;
    logic port_output_enable;
    logic port_output_enable_oe;
    logic [BUS_W-1:0] xfer_bus;
    logic xfer_bus_oe;
    logic [PAR_W-1:0] xfer_parity;
    logic xfer_parity_oe;
  } port_out_s;
endpackage : dph_pkg

// ### data_port_dma_handshake.sv
// dma handshake logic for two data ports plus host write forwarding to a port a peripheral
// assumes pins pass through pads that resolve the _oe triples; one clock, sync reset
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps

module data_port_dma_handshake (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [dph_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [dph_pkg::AXI_BYTES-1:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [dph_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire dph_pkg::port_in_s [dph_pkg::NUM_PORTS-1:0] i_port,
  output dph_pkg::port_out_s [dph_pkg::NUM_PORTS-1:0] o_port,
  input wire logic i_periph_select_n,
  input wire logic i_write_strobe,
  input wire logic [dph_pkg::HOST_W-1:0] i_host_data,
  output logic o_access_ack,
  output logic o_access_ack_oe,
  output logic o_periph_chip_select
);
  localparam int unsigned NP = dph_pkg::NUM_PORTS;
  localparam int unsigned WW = dph_pkg::WORD_W;

  // byte-lane merge for axi writes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [dph_pkg::AXI_BYTES-1:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < dph_pkg::AXI_BYTES; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // register hit test, used by the write and the read side
  function automatic logic reg_hit(input logic [dph_pkg::ADDR_W-1:0] a, input int unsigned p,
                                   input logic [1:0] idx);
    return (a[dph_pkg::ADDR_W-1:dph_pkg::PORT_BIT+1] == '0) && (a[dph_pkg::PORT_BIT] == p[0])
           && (a[dph_pkg::IDX_HI:dph_pkg::IDX_LO] == idx);
  endfunction : reg_hit

  // axi4-lite write channel state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_d, do_wr;
  logic aw_fire, w_fire;
  logic [dph_pkg::ADDR_W-1:0] awaddr_q, wr_addr;
  logic [31:0] wdata_q, wr_data;
  logic [dph_pkg::AXI_BYTES-1:0] wstrb_q, wr_strb;
  logic wr_known;

  assign aw_fire = i_s_axi_awvalid & o_s_axi_awready;
  assign w_fire = i_s_axi_wvalid & o_s_axi_wready;
  assign wr_addr = aw_have_q ? awaddr_q : i_s_axi_awaddr;
  assign wr_data = w_have_q ? wdata_q : i_s_axi_wdata;
  assign wr_strb = w_have_q ? wstrb_q : i_s_axi_wstrb;
  // address and data may come in either order; the write happens once both are in
  assign do_wr = (aw_have_q | aw_fire) & (w_have_q | w_fire) & ~o_s_axi_bvalid;
  assign aw_have_d = (aw_have_q | aw_fire) & ~do_wr;
  assign w_have_d = (w_have_q | w_fire) & ~do_wr;
  assign bvalid_d = (o_s_axi_bvalid & ~i_s_axi_bready) | do_wr;

  always_comb begin
    wr_known = 1'b0;
    for (int p = 0; p < NP; p++) begin
      wr_known |= reg_hit(wr_addr, p, dph_pkg::IDX_CTRL) | reg_hit(wr_addr, p, dph_pkg::IDX_STAT)
                  | reg_hit(wr_addr, p, dph_pkg::IDX_TXD);
    end
  end

  // write handshake; readies drop while a word is held or a response waits
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= dph_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      o_s_axi_awready <= ~aw_have_d & ~bvalid_d;
      o_s_axi_wready <= ~w_have_d & ~bvalid_d;
      o_s_axi_bvalid <= bvalid_d;
      if (aw_fire) begin
        awaddr_q <= i_s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_q <= i_s_axi_wdata;
        wstrb_q <= i_s_axi_wstrb;
      end
      if (do_wr) begin
        o_s_axi_bresp <= wr_known ? dph_pkg::RESP_OKAY : dph_pkg::RESP_SLVERR;
      end
    end
  end

  // per-port register state
  logic [dph_pkg::CTRL_W-1:0] ctrl_q [NP];
  logic [WW-1:0] txd_q [NP];
  logic [WW-1:0] rx_q [NP];
  logic tx_full_q [NP];
  logic rx_valid_q [NP];
  dph_pkg::xfer_e st_q [NP];

  // read side
  logic ar_fire, rvalid_d, rd_known;
  logic [31:0] rd_data;
  logic [NP-1:0] stat_rd;

  assign ar_fire = i_s_axi_arvalid & o_s_axi_arready;
  assign rvalid_d = (o_s_axi_rvalid & ~i_s_axi_rready) | ar_fire;

  always_comb begin
    rd_data = '0;
    rd_known = 1'b0;
    stat_rd = '0;
    for (int p = 0; p < NP; p++) begin
      if (reg_hit(i_s_axi_araddr, p, dph_pkg::IDX_CTRL)) begin
        rd_data = {{(32 - dph_pkg::CTRL_W){1'b0}}, ctrl_q[p]};
        rd_known = 1'b1;
      end
      if (reg_hit(i_s_axi_araddr, p, dph_pkg::IDX_STAT)) begin
        rd_data = '0;
        rd_data[WW-1:0] = rx_q[p];
        rd_data[dph_pkg::STAT_RX_VALID] = rx_valid_q[p];
        rd_data[dph_pkg::STAT_TX_FULL] = tx_full_q[p];
        rd_data[dph_pkg::STAT_BUSY] = (st_q[p] != dph_pkg::ST_IDLE);
        rd_known = 1'b1;
        stat_rd[p] = ar_fire;
      end
      if (reg_hit(i_s_axi_araddr, p, dph_pkg::IDX_TXD)) begin
        rd_data = {{(32 - WW){1'b0}}, txd_q[p]};
        rd_known = 1'b1;
      end
    end
  end

  // read handshake; data is captured with the address
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= '0;
      o_s_axi_rresp <= dph_pkg::RESP_OKAY;
    end else begin
      o_s_axi_arready <= ~rvalid_d;
      o_s_axi_rvalid <= rvalid_d;
      if (ar_fire) begin
        o_s_axi_rdata <= rd_data;
        o_s_axi_rresp <= rd_known ? dph_pkg::RESP_OKAY : dph_pkg::RESP_SLVERR;
      end
    end
  end

  // host select and strobe pass two stages before the host machine
  logic [dph_pkg::SYNC_STAGES-1:0] sel_sync_q, wr_sync_q;
  logic sel_s, wr_s;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sel_sync_q <= '1;
      wr_sync_q <= '1;
    end else begin
      sel_sync_q <= {sel_sync_q[0], i_periph_select_n};
      wr_sync_q <= {wr_sync_q[0], i_write_strobe};
    end
  end
  assign sel_s = sel_sync_q[dph_pkg::SYNC_STAGES-1];
  assign wr_s = wr_sync_q[dph_pkg::SYNC_STAGES-1];

  // host write forwarding to the port a peripheral
  dph_pkg::host_e hs_q, hs_d;
  logic [dph_pkg::HOST_W-1:0] host_data_q, host_byte;
  logic host_act_d;

  // byte taken straight from the pins on the start edge, so it leaves with chip select
  assign host_byte = (hs_q == dph_pkg::HS_IDLE) ? i_host_data : host_data_q;

  always_comb begin
    hs_d = hs_q;
    case (hs_q)
      // waits for the first edge at which both lows are seen while the port a mode is off
      dph_pkg::HS_IDLE: begin
        if (!sel_s && !wr_s && (ctrl_q[0][dph_pkg::CTRL_MODE_HI:dph_pkg::CTRL_MODE_LO]
                                 == dph_pkg::MODE_OFF)) begin
          hs_d = dph_pkg::HS_LOW;
        end
      end
      // one cycle low, then high to end the wait
      dph_pkg::HS_LOW: hs_d = dph_pkg::HS_WAIT;
      // the cycle ends only once the strobe release is seen
      dph_pkg::HS_WAIT: begin
        if (wr_s) begin
          hs_d = dph_pkg::HS_IDLE;
        end
      end
      default: hs_d = dph_pkg::HS_IDLE;
    endcase
  end
  assign host_act_d = (hs_d != dph_pkg::HS_IDLE);

  // idle is only reached after the strobe rises, so select may stay low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hs_q <= dph_pkg::HS_IDLE;
      host_data_q <= '0;
      o_access_ack <= 1'b1;
      o_access_ack_oe <= 1'b0;
      o_periph_chip_select <= 1'b0;
    end else begin
      hs_q <= hs_d;
      if (hs_q == dph_pkg::HS_IDLE && hs_d == dph_pkg::HS_LOW) begin
        host_data_q <= i_host_data;
      end
      // low while waiting, high at the next rise
      o_access_ack <= (hs_d != dph_pkg::HS_LOW);
      // line released once the strobe is back high
      o_access_ack_oe <= host_act_d;
      // chip select driven from a rising edge
      o_periph_chip_select <= host_act_d;
    end
  end

  // the same handshake logic for every port
  for (genvar g = 0; g < NP; g++) begin : g_port
    logic [dph_pkg::SY_N-1:0] sy1_q, sy2_q, pol;
    logic req_s, ack_s, stb_s, stb_prev_q, stb_fall;
    logic [WW-1:0] dly1_q, dly2_q, neg_cap_q, rx_word;
    logic rx_load, tx_done, wr_txd, wr_ctrl, act;
    logic [31:0] ctrl_m, txd_m;
    dph_pkg::mode_e mode;
    dph_pkg::xfer_e st_d;
    dph_pkg::port_out_s pin_d;

    assign mode = dph_pkg::mode_e'(ctrl_q[g][dph_pkg::CTRL_MODE_HI:dph_pkg::CTRL_MODE_LO]);
    assign pol = {ctrl_q[g][dph_pkg::CTRL_STB_INV], ctrl_q[g][dph_pkg::CTRL_ACK_INV],
                  ctrl_q[g][dph_pkg::CTRL_REQ_INV]};
    assign wr_ctrl = do_wr & reg_hit(wr_addr, g, dph_pkg::IDX_CTRL);
    assign wr_txd = do_wr & reg_hit(wr_addr, g, dph_pkg::IDX_TXD);
    assign act = (g == 0) ? host_act_d : 1'b0;
    // merged words kept whole so the register slices are taken from a named signal
    assign ctrl_m = merge_strb({{(32 - dph_pkg::CTRL_W){1'b0}}, ctrl_q[g]}, wr_data, wr_strb);
    assign txd_m = merge_strb({{(32 - WW){1'b0}}, txd_q[g]}, wr_data, wr_strb);

    // request, acknowledge and strobe through two stages
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        sy1_q <= '0;
        sy2_q <= '0;
        dly1_q <= '0;
        dly2_q <= '0;
        stb_prev_q <= 1'b0;
      end else begin
        sy1_q <= {i_port[g].port_write_strobe, i_port[g].dma_acknowledge,
                  i_port[g].dma_request};
        sy2_q <= sy1_q;
        // data delayed in step with the strobe synchroniser
        dly1_q <= {i_port[g].xfer_parity, i_port[g].xfer_bus};
        dly2_q <= dly1_q;
        stb_prev_q <= stb_s;
      end
    end
    assign req_s = sy2_q[dph_pkg::SY_REQ] ^ pol[dph_pkg::SY_REQ];
    assign ack_s = sy2_q[dph_pkg::SY_ACK] ^ pol[dph_pkg::SY_ACK];
    assign stb_s = sy2_q[dph_pkg::SY_STB] ^ pol[dph_pkg::SY_STB];
    assign stb_fall = stb_prev_q & ~stb_s;

    // inbound slave word taken at the falling edge mid-transfer
    always_ff @(negedge i_clk) begin
      if (i_rst) begin
        neg_cap_q <= '0;
      end else if (st_q[g] == dph_pkg::ST_XIN) begin
        neg_cap_q <= {i_port[g].xfer_parity, i_port[g].xfer_bus};
      end
    end

    // transfer machine; mode is only looked at from idle
    always_comb begin
      st_d = st_q[g];
      rx_load = 1'b0;
      rx_word = neg_cap_q;
      tx_done = 1'b0;
      case (st_q[g])
        // synchronised request polled here; a new word waits for rx_valid_q clear (in) or tx_full_q set (out)
        dph_pkg::ST_IDLE: begin
          case (mode)
            dph_pkg::MODE_SLV_IN: if (req_s && !rx_valid_q[g]) st_d = dph_pkg::ST_XIN;
            dph_pkg::MODE_SLV_OUT: if (req_s && tx_full_q[g]) st_d = dph_pkg::ST_XOUT;
            dph_pkg::MODE_MST_IN: if (!rx_valid_q[g]) st_d = dph_pkg::ST_REQ;
            default: st_d = dph_pkg::ST_IDLE;
          endcase
        end
        dph_pkg::ST_XIN: st_d = dph_pkg::ST_EIN;
        dph_pkg::ST_EIN: begin
          st_d = dph_pkg::ST_IDLE;
          rx_load = 1'b1;
        end
        dph_pkg::ST_XOUT: st_d = dph_pkg::ST_EOUT;
        dph_pkg::ST_EOUT: begin
          st_d = dph_pkg::ST_IDLE;
          tx_done = 1'b1;
        end
        // request held until the agent acknowledges
        dph_pkg::ST_REQ: if (ack_s) st_d = dph_pkg::ST_ACK;
        dph_pkg::ST_ACK: begin
          // word taken where the agent's strobe falls
          if (stb_fall) begin
            rx_load = 1'b1;
            rx_word = dly2_q;
          end
          // the strobe ends before acknowledge, so its fall lands here
          if (!ack_s) st_d = dph_pkg::ST_IDLE;
        end
        default: st_d = dph_pkg::ST_IDLE;
      endcase
    end

    // pin levels computed from the next state so every pin leaves a flip-flop
    always_comb begin
      pin_d = '0;
      // request is an output only in master mode
      pin_d.dma_request = (st_d == dph_pkg::ST_REQ) ^ pol[dph_pkg::SY_REQ];
      pin_d.dma_request_oe = (mode == dph_pkg::MODE_MST_IN);
      // acknowledge driven by the device in both slave modes
      pin_d.dma_acknowledge = ((st_d == dph_pkg::ST_XIN) || (st_d == dph_pkg::ST_XOUT))
                              ^ pol[dph_pkg::SY_ACK];
      pin_d.dma_acknowledge_oe = (mode == dph_pkg::MODE_SLV_IN) || (mode == dph_pkg::MODE_SLV_OUT);
      // write strobe only driven when enabled
      pin_d.port_write_strobe = (st_d == dph_pkg::ST_XIN) ^ pol[dph_pkg::SY_STB];
      pin_d.port_write_strobe_oe = (mode == dph_pkg::MODE_SLV_IN)
                                   & ctrl_q[g][dph_pkg::CTRL_STB_EN];
      // output enable only driven when enabled
      pin_d.port_output_enable = ((st_d == dph_pkg::ST_XOUT) || act) ^ pol[dph_pkg::SY_STB];
      pin_d.port_output_enable_oe = ((mode == dph_pkg::MODE_SLV_OUT) || act)
                                    & ctrl_q[g][dph_pkg::CTRL_OE_EN];
      // outbound bus from the loaded word
      pin_d.xfer_bus = txd_q[g][dph_pkg::BUS_W-1:0];
      pin_d.xfer_parity = txd_q[g][WW-1:dph_pkg::BUS_W];
      // driven from the start edge, released at the edge after the end
      pin_d.xfer_bus_oe = (st_d == dph_pkg::ST_XOUT) || (st_d == dph_pkg::ST_EOUT);
      // parity stays off the pins unless enabled
      pin_d.xfer_parity_oe = pin_d.xfer_bus_oe & ctrl_q[g][dph_pkg::CTRL_PAR_EN];
      // forwarded host byte on the low bus lanes
      if (act) begin
        pin_d.xfer_bus = {{(dph_pkg::BUS_W - dph_pkg::HOST_W){1'b0}}, host_byte};
        pin_d.xfer_bus_oe = 1'b1;
      end
    end

    // state and pins
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        st_q[g] <= dph_pkg::ST_IDLE;
        o_port[g] <= '0;
      end else begin
        st_q[g] <= st_d;
        o_port[g] <= pin_d;
      end
    end

    // control word; transfer modes pick up a change at the next idle
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        ctrl_q[g] <= dph_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
        ctrl_q[g] <= ctrl_m[dph_pkg::CTRL_W-1:0];
      end
    end

    // outbound word; a new write wins over the drain of the old one
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        txd_q[g] <= '0;
        tx_full_q[g] <= 1'b0;
      end else begin
        if (wr_txd) begin
          txd_q[g] <= txd_m[WW-1:0];
          tx_full_q[g] <= 1'b1;
        end else if (tx_done) begin
          tx_full_q[g] <= 1'b0;
        end
      end
    end

    // inbound word; arrival wins over the status read that clears it
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        rx_q[g] <= '0;
        rx_valid_q[g] <= 1'b0;
      end else begin
        if (rx_load) begin
          rx_q[g] <= rx_word;
          rx_valid_q[g] <= 1'b1;
        end else if (stat_rd[g]) begin
          rx_valid_q[g] <= 1'b0;
        end
      end
    end
  end
endmodule : data_port_dma_handshake

// ### dph_assertions.sv
// checker on the port a pins and the host forward path of the handshake block
// assumes port a runs with active-high pin polarity
`timescale 1ns/1ps
module dph_assertions (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire dph_pkg::port_in_s [dph_pkg::NUM_PORTS-1:0] i_port,
  input wire dph_pkg::port_out_s [dph_pkg::NUM_PORTS-1:0] o_port,
  input wire logic i_periph_select_n,
  input wire logic i_write_strobe,
  input wire logic o_access_ack,
  input wire logic o_access_ack_oe,
  input wire logic o_periph_chip_select
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_fwd_sync_wait: assert property ($rose(o_periph_chip_select) |->
    !$past(i_write_strobe, 3) && !$past(i_periph_select_n, 3)) else $error("forward before sync");
  a_ack_low_high: assert property ($rose(o_access_ack_oe) |-> !o_access_ack ##1 o_access_ack)
    else $error("ack not low then high");
  a_ack_hold: assert property (o_access_ack_oe && !i_write_strobe |=> o_access_ack_oe)
    else $error("ack released while strobe low");
  a_ack_release: assert property ($rose(i_write_strobe) && o_access_ack_oe |->
    ##[1:4] !o_access_ack_oe) else $error("ack line not released");
  a_fwd_drive: assert property (o_access_ack_oe |->
    o_periph_chip_select && o_port[0].xfer_bus_oe) else $error("forward pins not driven");
  a_strobe_pulse: assert property (o_port[0].port_write_strobe &&
    o_port[0].port_write_strobe_oe |=> !o_port[0].port_write_strobe) else $error("strobe too long");
  a_req_synced: assert property ($rose(o_port[0].dma_acknowledge) &&
    o_port[0].dma_acknowledge_oe |-> $past(i_port[0].dma_request, 2)) else $error("ack unsynced");
  a_bus_release: assert property ($fell(o_port[0].port_output_enable) |=>
    !o_port[0].xfer_bus_oe) else $error("bus not released");
  a_req_drop: assert property ($rose(i_port[0].dma_acknowledge) && o_port[0].dma_request |->
    ##[1:4] !o_port[0].dma_request) else $error("request not dropped");
endmodule : dph_assertions

bind data_port_dma_handshake dph_assertions dph_assertions_inst (.i_clk(i_clk), .i_rst(i_rst),
  .i_port(i_port), .o_port(o_port), .i_periph_select_n(i_periph_select_n),
  .i_write_strobe(i_write_strobe), .o_access_ack(o_access_ack),
  .o_access_ack_oe(o_access_ack_oe), .o_periph_chip_select(o_periph_chip_select));

// ### dph_agent.sv
// far-side dma agent for one port: slave requester, data source and sink, master acknowledger
// assumes active-high pins; the bench pulses i_go once for each slave word
`timescale 1ns/1ps
module dph_agent (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_slow,
  input wire logic [17:0] i_word,
  input wire dph_pkg::port_out_s i_out,
  output wire dph_pkg::port_in_s o_in,
  output logic [17:0] o_seen,
  output logic o_done
);
  logic req_q = 1'h0;
  logic [3:0] ph_q = 4'h0;
  logic dev_ack;
  logic drv;
  assign dev_ack = i_out.dma_acknowledge && i_out.dma_acknowledge_oe;
  // data only while requesting or acknowledging, else inverse so stale samples fail
  assign drv = req_q || ph_q >= 4'h5;
  assign o_in.xfer_bus = drv ? i_word[15:0] : ~i_word[15:0];
  assign o_in.xfer_parity = drv ? i_word[17:16] : ~i_word[17:16];
  assign o_in.dma_request = req_q;
  // ack answers the request, strobe nested inside ack
  assign o_in.dma_acknowledge = ph_q >= 4'h5;
  assign o_in.port_write_strobe = ph_q >= 4'h7 && ph_q < 4'hA;
  // request held until acknowledged, sink captures on ack
  always @(posedge i_clk) begin
    if (i_go) req_q <= 1'h1;
    else if (dev_ack) req_q <= 1'h0;
    // undriven parity pins read as their pull-up level
    if (dev_ack && i_out.xfer_bus_oe)
      o_seen <= {i_out.xfer_parity_oe ? i_out.xfer_parity : 2'h3, i_out.xfer_bus};
  end
  // master phase count; slow start delays the ack by three cycles
  always @(posedge i_clk) begin
    o_done <= ph_q == 4'hF;
    if (ph_q != 4'h0) ph_q <= ph_q + 4'h1;
    else if (i_out.dma_request && i_out.dma_request_oe) ph_q <= i_slow ? 4'h1 : 4'h4;
  end
endmodule : dph_agent

// ### tb_top.sv
// self-checking bench: axi4-lite registers, dma handshakes on both ports, host forwarding
// assumes the checker binds itself to the design and two agents model the far side
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0, sel_n = 1'h1, wstb = 1'h1;
  logic flag = 1'h0;
  logic awr, wrdy, bv, arr, rv, ack, ack_oe, cs;
  logic [7:0] awa = 8'h00, ara = 8'h00, hdata = 8'h00, cur = 8'h0C;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [1:0] bresp, rresp, r;
  wire [1:0] done;
  logic [1:0] go = 2'h0, slow = 2'h0;
  logic [17:0] m;
  logic [17:0] word [2] = '{18'h0, 18'h0};
  logic [17:0] seen [2];
  logic [7:0] tab [3] = '{8'h0E, 8'h1E, 8'h16};
  int num_errors = 0, num_checks = 0, n;
  wire dph_pkg::port_in_s [1:0] pin;
  dph_pkg::port_out_s [1:0] pout;
  always #2 clk = ~clk;
  data_port_dma_handshake data_port_dma_handshake_inst (.i_clk(clk), .i_rst(rst),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv),
    .i_s_axi_rready(rry), .i_port(pin), .o_port(pout), .i_periph_select_n(sel_n),
    .i_write_strobe(wstb), .i_host_data(hdata), .o_access_ack(ack), .o_access_ack_oe(ack_oe),
    .o_periph_chip_select(cs));
  for (genvar p = 0; p < 2; p++) begin : g_agent
    dph_agent dph_agent_inst (.i_clk(clk), .i_go(go[p]), .i_slow(slow[p]), .i_word(word[p]),
      .i_out(pout[p]), .o_in(pin[p]), .o_seen(seen[p]), .o_done(done[p]));
  end
  // flags any drive of the port a parity or output enable pin that the control word disabled
  always @(posedge clk)
    if ((pout[0].xfer_parity_oe && !cur[4]) || (pout[0].port_output_enable_oe && !cur[3]))
      flag <= 1'h1;
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int t;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    t = 0;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
      t++;
    end while (bv !== 1'h1 && t < 50);
    bry <= 1'h0;
    chk("bvalid", {31'h0, bv}, 32'h1);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    int t;
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    t = 0;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
      t++;
    end while (rv !== 1'h1 && t < 50);
    v = rdat;
    rr = rresp;
    rry <= 1'h0;
    chk("rvalid", {31'h0, rv}, 32'h1);
  endtask : axi_rd
  // status polls clear rx_valid, so the word is taken from the read that saw it
  task automatic get_word(input int p, output logic [31:0] v);
    int t;
    t = 0;
    do begin
      axi_rd(8'(p * 16 + 4), v, r);
      t++;
    end while (v[18] !== 1'h1 && t < 40);
    chk("rx_valid", {31'h0, v[18]}, 32'h1);
  endtask : get_word
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    void'($urandom(32'h90B9));
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    axi_rd(8'h00, d, r);
    chk("ctrl_reset", d, 32'h0000000C);
    axi_wr(8'h0C, 32'h0, 2'h2);
    axi_rd(8'h1C, d, r);
    chk("unmapped_rd", {d[29:0], r}, 32'h00000002);
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      axi_wr(8'(p * 16), 32'h0000001D, 2'h0);
      for (int k = 0; k < 2; k++) begin
        word[p] <= 18'($urandom);
        go[p] <= 1'h1;
        @(posedge clk);
        go[p] <= 1'h0;
        get_word(p, d);
        chk("slave_in", {14'h0, d[17:0]}, {14'h0, word[p]});
      end
    end
    $display("test slave_in done");
    foreach (tab[i]) begin
      axi_wr(8'h00, {24'h0, tab[i]}, 2'h0);
      word[0] <= 18'($urandom);
      @(posedge clk);
      // pins are judged only once the new control word drives them
      cur <= tab[i];
      flag <= 1'h0;
      axi_wr(8'h08, {14'h0, word[0]}, 2'h0);
      go[0] <= 1'h1;
      @(posedge clk);
      go[0] <= 1'h0;
      repeat (12) @(posedge clk);
      m = cur[4] ? word[0] : {2'h3, word[0][15:0]};
      chk("slave_out", {14'h0, seen[0]}, {14'h0, m});
      chk("disabled_pin", {31'h0, flag}, 32'h0);
    end
    $display("test slave_out done");
    cur <= 8'h1F;
    for (int s = 0; s < 2; s++) begin
      word[0] <= 18'($urandom);
      slow[0] <= s[0];
      axi_wr(8'h00, 32'h0000001F, 2'h0);
      for (n = 0; n < 60 && done[0] !== 1'h1; n++) @(posedge clk);
      repeat (4) @(posedge clk);
      axi_wr(8'h00, 32'h0000000C, 2'h0);
      get_word(0, d);
      chk("master_in", {14'h0, d[17:0]}, {14'h0, word[0]});
    end
    $display("test master_in done");
    sel_n <= 1'h0;
    for (int k = 0; k < 2; k++) begin
      hdata <= 8'($urandom);
      wstb <= 1'h0;
      for (n = 0; n < 20 && ack_oe !== 1'h1; n++) @(posedge clk);
      chk("fwd_ack_cs", {30'h0, ack, cs}, 32'h00000001);
      chk("fwd_data", {24'h0, pout[0].xfer_bus[7:0]}, {24'h0, hdata});
      @(posedge clk);
      chk("fwd_ack_high", {31'h0, ack}, 32'h00000001);
      wstb <= 1'h1;
      for (n = 0; n < 20 && ack_oe !== 1'h0; n++) @(posedge clk);
      chk("fwd_release", {31'h0, cs}, 32'h0);
    end
    sel_n <= 1'h1;
    $display("test forward done");
    test_done();
  end
  // watchdog: the sequence needs under 3000 cycles, this allows about 10000
  initial begin
    #40000;
    num_errors++;
    test_done();
  end
endmodule : tb_top
